// file: rtl/rtr_consts.vh
// rtr_consts.vh: constants of the temperature result register block.
// assumes: included by bare name from the divider and the result register design files.
`ifndef RTR_CONSTS_VH
`define RTR_CONSTS_VH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define RTR_IDX_P3_FRAC 8'hEC
`define RTR_IDX_P4_INT 8'hED
`define RTR_IDX_P4_FRAC 8'hEE
`define RTR_IDX_CYCLES 8'hEF
`define RTR_IDX_P3_AVG_INT 8'hF4
`define RTR_IDX_P3_AVG_FRAC 8'hF5
`define RTR_IDX_P4_AVG_INT 8'hF6
`define RTR_IDX_P4_AVG_FRAC 8'hF7
`define RTR_IDX_IRQ_STATUS 8'hF8
`define RTR_IDX_IRQ_MASK 8'hF9
`define RTR_IDX_CFG 8'hFA
`define RTR_IDX_P3_INT 8'hFB

// ----------------------------------------
// field layout and limits
// ----------------------------------------
`define RTR_INT_MAX 15'h7FFF
`define RTR_FRAC_MAX 16'hFFFF
`define RTR_CYC_MAX 8'hFF
`define RTR_IRQ_DONE 0
`define RTR_IRQ_ERR 1
`define RTR_CFG_RESET 8'h01
`define RTR_SUM_W 39
`define RTR_DIV_STEPS 6'h27

`endif

// file: rtl/rtr_sync.v
// rtr_sync.v: three-stage synchroniser for a level from another domain.
// assumes: sys_clk domain; output changes once stages two and three agree.
`timescale 1ns/10ps
module rtr_sync (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // level in and out
    input wire async_in,
    output reg sync_out
);

reg s1_r;
reg s2_r;
reg s3_r;

// stage one is read only by stage two
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        sync_out <= 1'b0;
    end else if (clk_en) begin
        s1_r <= async_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            sync_out <= s3_r;
        end
    end
end

endmodule

// file: rtl/rtr_divider.v
// rtr_divider.v: serial restoring divider, sum of 15.16 results by cycle count.
// assumes: start is one cycle; divisor never zero when start is taken.
`timescale 1ns/10ps
`include "rtr_consts.vh"
module rtr_divider (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // operands
    input wire start,
    input wire [`RTR_SUM_W-1:0] dividend,
    input wire [7:0] divisor,
    // result
    output reg busy,
    output reg [`RTR_SUM_W-1:0] quotient
);

reg [`RTR_SUM_W-1:0] rem_r;
reg [`RTR_SUM_W-1:0] dvd_r;
reg [5:0] step_r;
wire [`RTR_SUM_W-1:0] trial;
wire fits;

// one quotient bit a cycle keeps the area down at the cost of 39 cycles
assign trial = {rem_r[`RTR_SUM_W-2:0], dvd_r[`RTR_SUM_W-1]};
assign fits = (trial >= {31'h0, divisor});

always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        rem_r <= {`RTR_SUM_W{1'b0}};
        dvd_r <= {`RTR_SUM_W{1'b0}};
        step_r <= 6'h0;
        busy <= 1'b0;
        quotient <= {`RTR_SUM_W{1'b0}};
    end else if (clk_en) begin
        if (start) begin
            rem_r <= {`RTR_SUM_W{1'b0}};
            dvd_r <= dividend;
            step_r <= `RTR_DIV_STEPS;
            busy <= 1'b1;
        end else if (busy) begin
            rem_r <= fits ? (trial - {31'h0, divisor}) : trial;
            dvd_r <= {dvd_r[`RTR_SUM_W-2:0], 1'b0};
            quotient <= {quotient[`RTR_SUM_W-2:0], fits};
            step_r <= step_r - 6'h1;
            if (step_r == 6'h1) begin
                busy <= 1'b0;
            end
        end
    end
end

endmodule

// file: rtl/rtr_result_regs.v
// rtr_result_regs.v: temperature result registers, cycle count and averages.
// assumes: measurement front end on sys_clk gives one-cycle result strobes;
// sequence start/end levels arrive from the sequencer in another domain.
// assumes: a sequence level holds for the whole sequence and drops for at least
// two cycles between sequences, else the synchronised start edge is lost.
// assumes: cycles_setting stays steady while a sequence runs.
// limitation: averaging takes about eighty-five cycles after the done flag, and
// the average registers show the previous sequence until then.
//
// Notes on behaviour
// - the third port's fraction of charge time is readable in its own register.
// - a fraction field is one reference period in 16 binary fraction bits.
// - a fraction field reaches at most FFFF, just under one period.
// - the fourth port's integer charge time is a read-only 15-bit value.
// - the integer field counts whole reference periods in binary.
// - the integer field saturates at 7FFF periods.
// - an 8-bit counter holds the error-free temperature cycles of either sequence.
// - only an error-free temperature run adds one; failed runs leave it.
// - the counter is the divisor when the averages are formed.
// - when the configured cycles finish, the done flag is set and irq raised if enabled.
// - each average is the port's summed results divided by the counter.
`timescale 1ns/10ps
`include "rtr_consts.vh"
module rtr_result_regs (
    // clock, reset, enable
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // measurement front end, sys_clk domain
    input wire meas_valid,
    input wire meas_error,
    input wire meas_port4,
    input wire [16:0] meas_int,
    input wire [15:0] meas_frac,
    // sequencer levels from another domain
    input wire flow_and_temp_sequence,
    input wire temp_only_sequence,
    input wire [7:0] cycles_setting,
    // interrupt
    output wire irq
);

// ----------------------------------------
// synchronised sequence levels
// ----------------------------------------
wire seq_a_s;
wire seq_b_s;
wire seq_any;
reg seq_any_r;
wire seq_start;

// each sequence level has its own synchroniser; the two are never high
// together, so their or is safe once both are synchronised
rtr_sync u_sync_a (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(flow_and_temp_sequence),
    .sync_out(seq_a_s)
);

rtr_sync u_sync_b (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(temp_only_sequence),
    .sync_out(seq_b_s)
);

// a temperature sequence runs while either level is high; the start edge
// comes four to five cycles after the level, through the synchronisers,
// so results taken before then are not part of the sequence
assign seq_any = seq_a_s | seq_b_s;
assign seq_start = seq_any & ~seq_any_r;

// ----------------------------------------
// result capture
// ----------------------------------------
// the direct registers follow every good result, inside a sequence or not
reg [14:0] p3_int_r;
reg [15:0] p3_frac_r;
reg [14:0] p4_int_r;
reg [15:0] p4_frac_r;
reg [14:0] meas_int_sat;

// the front end may hand over a count two bits wider than the field; anything
// above the top of the field is pinned there rather than wrapped, so a very
// slow charge never reads back as a short one
// saturate integer
always @* begin
    if (meas_int > {2'b00, `RTR_INT_MAX}) begin
        meas_int_sat = `RTR_INT_MAX;
    end else begin
        meas_int_sat = meas_int[14:0];
    end
end

always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        p3_int_r <= 15'h0;
        p3_frac_r <= 16'h0;
        p4_int_r <= 15'h0;
        p4_frac_r <= 16'h0;
        seq_any_r <= 1'b0;
    end else if (clk_en) begin
        seq_any_r <= seq_any;
        // errored runs keep the previous good result
        if (meas_valid && !meas_error) begin
            if (meas_port4) begin
                p4_int_r <= meas_int_sat;
                p4_frac_r <= meas_frac; // full 16-bit fraction
            end else begin
                p3_int_r <= meas_int_sat;
                p3_frac_r <= meas_frac;
            end
        end
    end
end

// ----------------------------------------
// cycle counter and sums
// ----------------------------------------
reg [7:0] cycles_r;
reg [`RTR_SUM_W-1:0] sum_r [0:1];
reg [`RTR_SUM_W-1:0] avg_r [0:1];
reg done_pend_r;
reg seq_done_pulse;
reg [7:0] runs_r;
wire good_run;

// a good run is an error-free result while a sequence is open; results outside
// a sequence update the direct registers but touch neither count nor sums
assign good_run = meas_valid & ~meas_error & seq_any;

always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        cycles_r <= 8'h0;
        runs_r <= 8'h0;
        done_pend_r <= 1'b0;
        seq_done_pulse <= 1'b0;
    end else if (clk_en) begin
        seq_done_pulse <= 1'b0;
        if (seq_start) begin
            cycles_r <= 8'h0;
            runs_r <= 8'h0;
            done_pend_r <= 1'b1;
        end else if (meas_valid && seq_any && meas_port4) begin
            // the fourth port closes one temperature cycle, good or bad
            runs_r <= runs_r + 8'h1;
            if (good_run && cycles_r != `RTR_CYC_MAX) begin
                cycles_r <= cycles_r + 8'h1;
            end
            if (done_pend_r && (runs_r + 8'h1) == cycles_setting) begin
                done_pend_r <= 1'b0;
                seq_done_pulse <= 1'b1;
            end
        end
    end
end

// 39 bits hold 255 full-scale 31-bit results; the counter saturates at the
// same number, so a longer sequence cannot be averaged exactly in any case
// per-port sums of 15.16 results
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sum
        always @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                sum_r[gi] <= {`RTR_SUM_W{1'b0}};
            end else if (clk_en) begin
                if (seq_start) begin
                    sum_r[gi] <= {`RTR_SUM_W{1'b0}};
                end else if (good_run && (meas_port4 == (gi == 1))) begin
                    sum_r[gi] <= sum_r[gi] + {8'h0, meas_int_sat, meas_frac};
                end
            end
        end
    end
endgenerate

// ----------------------------------------
// averaging, one port after the other
// ----------------------------------------
// one shared divider serves both ports; it doubles the latency but halves
// the area, and the averages are needed only once per sequence
reg div_start_r;
reg div_port_r;
reg [1:0] avg_state_r;
wire div_busy;
wire [`RTR_SUM_W-1:0] div_q;

// averaging states
localparam AVG_IDLE = 2'b00;
localparam AVG_RUN = 2'b01;
localparam AVG_WAIT = 2'b10;

// the divisor is the live counter, steady once the done pulse has passed
// because no run is counted after the last one of a sequence
rtr_divider u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(div_start_r),
    .dividend(sum_r[div_port_r]),
    .divisor(cycles_r),
    .busy(div_busy),
    .quotient(div_q)
);

// counter as divisor, started on sequence done
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        avg_state_r <= AVG_IDLE;
        div_start_r <= 1'b0;
        div_port_r <= 1'b0;
        avg_r[0] <= {`RTR_SUM_W{1'b0}};
        avg_r[1] <= {`RTR_SUM_W{1'b0}};
    end else if (clk_en) begin
        div_start_r <= 1'b0;
        case (avg_state_r)
            AVG_IDLE: begin
                // no good cycle means nothing to average; keep old values
                if (seq_done_pulse && cycles_r != 8'h0) begin
                    div_port_r <= 1'b0;
                    div_start_r <= 1'b1;
                    avg_state_r <= AVG_RUN;
                end
            end
            AVG_RUN: begin
                avg_state_r <= AVG_WAIT;
            end
            AVG_WAIT: begin
                if (!div_busy) begin
                    avg_r[div_port_r] <= div_q;
                    if (!div_port_r) begin
                        div_port_r <= 1'b1;
                        div_start_r <= 1'b1;
                        avg_state_r <= AVG_RUN;
                    end else begin
                        avg_state_r <= AVG_IDLE;
                    end
                end
            end
            default: begin
                avg_state_r <= AVG_IDLE;
            end
        endcase
    end
end

// average results saturate like the direct results; the quotient can exceed
// the field when port three has more good results than the counter, which
// counts only the fourth port
wire [14:0] avg_int [0:1];
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_avg
        assign avg_int[gi] = (avg_r[gi][`RTR_SUM_W-1:31] != 8'h0) ? `RTR_INT_MAX
                                                                  : avg_r[gi][30:16];
    end
endgenerate

// ----------------------------------------
// interrupts and configuration
// ----------------------------------------
reg [1:0] irq_status_r;
reg [1:0] irq_mask_r;
reg [7:0] cfg_r;
wire [1:0] irq_set;
wire wr_status;

// bit 0 marks a finished sequence, bit 1 an errored run inside one
assign irq_set = {meas_valid & meas_error & seq_any, seq_done_pulse};
assign wr_status = reg_wr && reg_addr == `RTR_IDX_IRQ_STATUS;

// sticky status, write one to clear; a new event wins over the clear
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        irq_status_r <= 2'b00;
        irq_mask_r <= 2'b00;
        cfg_r <= `RTR_CFG_RESET;
    end else if (clk_en) begin
        irq_status_r <= (irq_status_r & ~(wr_status ? reg_wdata[1:0] : 2'b00)) | irq_set;
        if (reg_wr && reg_addr == `RTR_IDX_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[1:0];
        end
        if (reg_wr && reg_addr == `RTR_IDX_CFG) begin
            cfg_r <= reg_wdata[7:0];
        end
    end
end

// kept combinational so that a mask or enable write takes effect at once
// interrupt gated by mask and global enable
assign irq = cfg_r[0] & |(irq_status_r & irq_mask_r);

// ----------------------------------------
// read port
// ----------------------------------------
reg [15:0] rd_mux;

always @* begin
    case (reg_addr)
        `RTR_IDX_P3_INT: rd_mux = {1'b0, p3_int_r};
        `RTR_IDX_P3_FRAC: rd_mux = p3_frac_r;
        `RTR_IDX_P4_INT: rd_mux = {1'b0, p4_int_r};
        `RTR_IDX_P4_FRAC: rd_mux = p4_frac_r;
        `RTR_IDX_CYCLES: rd_mux = {8'h0, cycles_r};
        `RTR_IDX_P3_AVG_INT: rd_mux = {1'b0, avg_int[0]};
        `RTR_IDX_P3_AVG_FRAC: rd_mux = avg_r[0][15:0];
        `RTR_IDX_P4_AVG_INT: rd_mux = {1'b0, avg_int[1]};
        `RTR_IDX_P4_AVG_FRAC: rd_mux = avg_r[1][15:0];
        `RTR_IDX_IRQ_STATUS: rd_mux = {14'h0, irq_status_r};
        `RTR_IDX_IRQ_MASK: rd_mux = {14'h0, irq_mask_r};
        `RTR_IDX_CFG: rd_mux = {8'h0, cfg_r};
        default: rd_mux = 16'h0;
    endcase
end

// returning zero outside the answer cycle keeps a stale value from being
// mistaken for a fresh one by a host that samples late
// read data stands one cycle after the strobe, zero otherwise
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        reg_rdata <= 16'h0;
    end else if (clk_en) begin
        reg_rdata <= reg_rd ? rd_mux : 16'h0;
    end
end

endmodule

// file: bench/rtr_host_model.sv
// rtr_host_model.sv: host that reads the result registers over the plain port.
// assumes: one clock; strobes change by nonblocking assignment after a rising edge.
`timescale 1ns/10ps
module rtr_host_model (
    // clock
    input wire sys_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire [15:0] reg_rdata
);
    // bus idle from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle write strobe; data then turned over so stale data never match
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // register read back
    // answer stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule

// file: bench/rtr_result_chk.sv
// rtr_result_chk.sv: port-level checker of the result register block.
// assumes: bound to rtr_result_regs; one sys_clk domain.
`timescale 1ns/10ps
`include "rtr_consts.vh"
module rtr_result_chk (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    // front end and interrupt
    input wire meas_valid,
    input wire meas_error,
    input wire meas_port4,
    input wire [16:0] meas_int,
    input wire [15:0] meas_frac,
    input wire irq
);
    reg [15:0] p3f_r;
    reg [15:0] p4f_r;
    reg [14:0] p4i_r;
    wire good = clk_en && meas_valid && !meas_error;
    // last good result per port; errored ones must leave the registers alone
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            p3f_r <= 16'h0000;
            p4f_r <= 16'h0000;
            p4i_r <= 15'h0000;
        end else if (good && meas_port4) begin
            p4f_r <= meas_frac;
            p4i_r <= (meas_int > 17'h07FFF) ? 15'h7FFF : meas_int[14:0];
        end else if (good) begin
            p3f_r <= meas_frac;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside answer cycle");
    chk_p3_frac: assert property (reg_rd && clk_en && reg_addr == `RTR_IDX_P3_FRAC |=> reg_rdata == $past(p3f_r))
        else $error("third port fraction wrong");
    chk_p4_int: assert property (reg_rd && clk_en && reg_addr == `RTR_IDX_P4_INT |=> reg_rdata == {1'b0, $past(p4i_r)})
        else $error("fourth port integer wrong");
    chk_p4_frac: assert property (reg_rd && clk_en && reg_addr == `RTR_IDX_P4_FRAC |=> reg_rdata == $past(p4f_r))
        else $error("fourth port fraction wrong");
    chk_count_width: assert property (reg_rd && clk_en && reg_addr == `RTR_IDX_CYCLES |=> reg_rdata[15:8] == 8'h00)
        else $error("cycle count wider than 8 bits");
    chk_unmapped_zero: assert property (reg_rd && clk_en && reg_addr < 8'hEC |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_irq_cause: assert property ($rose(irq) |-> $past(reg_wr) || $past(meas_valid) || $past(meas_valid, 2))
        else $error("interrupt rose without cause");
    chk_irq_masked: assert property (reg_wr && clk_en && ((reg_addr == `RTR_IDX_IRQ_MASK && reg_wdata == 16'h0000) || (reg_addr == `RTR_IDX_CFG && !reg_wdata[0])) |=> !irq)
        else $error("interrupt high while disabled");
    cover property (reg_rd && reg_addr == `RTR_IDX_CYCLES);
    cover property ($rose(irq));
    cover property (meas_valid && meas_port4 && meas_int > 17'h07FFF);
endmodule

// file: bench/test_rtr_result_regs.sv
// test_rtr_result_regs.sv: self-checking bench of the result register block.
// assumes: host model on the register port; bench plays front end and sequencer.
`timescale 1ns/10ps
`include "rtr_consts.vh"
module test_rtr_result_regs;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic meas_valid = 1'b0;
    logic meas_error = 1'b0;
    logic meas_port4 = 1'b0;
    logic [16:0] meas_int = 17'h00000;
    logic [15:0] meas_frac = 16'h0000;
    logic [1:0] seq_lvl = 2'b00;
    logic clk_en = 1'b1;
    logic [7:0] cycles_setting = 8'h03;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val, p3f, p4f;
    logic reg_wr, reg_rd, irq, in_seq;
    logic [14:0] p4i;
    logic [31:0] rnd = 32'hC304;
    int mismatches = 0;
    int checked = 0;
    int cnt, runs;
    longint sum3, sum4, q;
    rtr_result_regs u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .meas_valid(meas_valid), .meas_error(meas_error),
        .meas_port4(meas_port4), .meas_int(meas_int), .meas_frac(meas_frac),
        .flow_and_temp_sequence(seq_lvl[1]), .temp_only_sequence(seq_lvl[0]),
        .cycles_setting(cycles_setting), .irq(irq));
    rtr_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // free-running clock and a two-cycle reset
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
    end
    // watchdog: the whole run is well under two thousand cycles
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [15:0] exp);
        u_host.rd(a, rd_val);
        check(rd_val, exp);
    endtask
    task automatic irq_is(input logic exp);
        #1 check({15'h0000, irq}, {15'h0000, exp});
    endtask
    // one result pulse; the model keeps last values and the sequence sums
    task automatic send(input logic p4, input logic err, input logic [16:0] i,
                        input logic [15:0] f);
        logic [14:0] si;
        si = (i > 17'h07FFF) ? 15'h7FFF : i[14:0];
        @(posedge sys_clk);
        meas_valid <= 1'b1;
        meas_error <= err;
        meas_port4 <= p4;
        meas_int <= i;
        meas_frac <= f;
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        if (!err && p4) begin
            p4i = si;
            p4f = f;
            sum4 += {si, f};
            cnt += in_seq;
        end else if (!err) begin
            p3f = f;
            sum3 += {si, f};
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        in_seq = 1'b0;
        {p3f, p4f, p4i} = 47'h0;
        wait (!sys_rst);
        reg_check(`RTR_IDX_P4_INT, 16'h0000);
        reg_check(`RTR_IDX_CFG, 16'h0001);
        reg_check(8'h10, 16'h0000);
        // both ports, small and saturating integers, then an errored result
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            send(k[0], 1'b0, {k[1], rnd[15:0]}, (k == 3) ? 16'hFFFF : rnd[31:16]);
        end
        send(1'b1, 1'b1, 17'h00123, 16'h4567);
        reg_check(`RTR_IDX_P3_FRAC, p3f);
        reg_check(`RTR_IDX_P4_INT, {1'b0, p4i});
        reg_check(`RTR_IDX_P4_FRAC, p4f);
        u_host.wr(`RTR_IDX_P3_FRAC, ~p3f);
        reg_check(`RTR_IDX_P3_FRAC, p3f);
        // a result offered while the block is frozen must be ignored
        @(posedge sys_clk);
        clk_en <= 1'b0;
        meas_valid <= 1'b1;
        meas_error <= 1'b0;
        meas_port4 <= 1'b0;
        meas_frac <= ~p3f;
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        clk_en <= 1'b1;
        reg_check(`RTR_IDX_P3_FRAC, p3f);
        // one sequence of each kind, an errored run inside each
        for (int s = 0; s < 2; s++) begin
            runs = 3 - s;
            cycles_setting <= runs[7:0];
            u_host.wr(`RTR_IDX_IRQ_MASK, 16'h0001);
            seq_lvl <= s ? 2'b01 : 2'b10;
            repeat (8) @(posedge sys_clk);
            in_seq = 1'b1;
            {cnt, sum3, sum4} = 0;
            reg_check(`RTR_IDX_CYCLES, 16'h0000);
            for (int r = 0; r < runs; r++) begin
                rnd = lfsr(rnd);
                send(1'b0, 1'b0, {7'h00, rnd[9:0]}, rnd[31:16]);
                if (r == runs - 1)
                    irq_is(1'b0);
                send(1'b1, r == 1, {7'h00, rnd[25:16]}, rnd[15:0]);
            end
            in_seq = 1'b0;
            repeat (150) @(posedge sys_clk);
            irq_is(1'b1);
            reg_check(`RTR_IDX_IRQ_STATUS, 16'h0003);
            reg_check(`RTR_IDX_CYCLES, cnt[15:0]);
            q = sum3 / cnt;
            reg_check(`RTR_IDX_P3_AVG_INT, {1'b0, q[30:16]});
            reg_check(`RTR_IDX_P3_AVG_FRAC, q[15:0]);
            q = sum4 / cnt;
            reg_check(`RTR_IDX_P4_AVG_INT, {1'b0, q[30:16]});
            reg_check(`RTR_IDX_P4_AVG_FRAC, q[15:0]);
            u_host.wr(`RTR_IDX_IRQ_MASK, 16'h0000);
            irq_is(1'b0);
            u_host.wr(`RTR_IDX_IRQ_MASK, 16'h0003);
            irq_is(1'b1);
            u_host.wr(`RTR_IDX_CFG, 16'h0000);
            irq_is(1'b0);
            u_host.wr(`RTR_IDX_CFG, 16'h0001);
            irq_is(1'b1);
            u_host.wr(`RTR_IDX_IRQ_STATUS, 16'h0003);
            irq_is(1'b0);
            seq_lvl <= 2'b00;
            repeat (8) @(posedge sys_clk);
        end
        wrap_up();
    end
endmodule
bind rtr_result_regs rtr_result_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_error(meas_error), .meas_port4(meas_port4), .meas_int(meas_int),
    .meas_frac(meas_frac), .irq(irq));
